//--- rtl/io_port_mux_unit.sv
// Purpose: Two 8-bit general purpose I/O ports with peripheral multiplexing
// Assumes: Registers reached by a simple 16-bit peripheral strobe bus
// Notes:   Pin drive and read data are registered, one clock behind their causes
//          Only the low byte of each register is stored; the upper byte reads zero
//          Port 2 pins 2, 4 and 5 never drive; their control and latch bits are storage
//          Pin state trails the pads by two clocks through the synchroniser

`timescale 1ns/1ps

module io_port_mux_unit (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic [7:0]  GENERAL_CHIP_SELECT,
    input  wire logic        SERIAL1_TRANSMIT_DATA,
    input  wire logic        SERIAL1_INTERRUPT_OUT,
    input  wire logic        SERIAL1_MODE0_TX,
    input  wire logic        TRANSMIT_BUFFER_DATA,
    output logic             SERIAL1_RECEIVE_DATA,
    output logic [7:0]       P2_PIN_LEVEL,
    input  wire logic [7:0]  P1_PAD_IN,
    output logic      [7:0]  P1_PAD_OUT,
    input  wire logic [7:0]  P2_PAD_IN,
    output logic      [7:0]  P2_PAD_OUT,
    output logic      [7:0]  P2_PAD_OE
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////////

    // Storage, low byte of each register
    logic [7:0]  p1_dir_r;
    logic [7:0]  p2_dir_r;
    logic [7:0]  p1_con_r;
    logic [7:0]  p2_con_r;
    logic [7:0]  p1_lth_r;
    logic [7:0]  p2_lth_r;

    // Read data and its next value
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    // Registered pad drive and enables
    logic [7:0]  p1_out_r;
    logic [7:0]  p1_out_nxt;
    logic [7:0]  p2_out_r;
    logic [7:0]  p2_out_nxt;
    logic [7:0]  p2_oe_r;
    logic [7:0]  p2_oe_nxt;

    // Synchronised pad levels per port
    logic [7:0]  p1_sync;
    logic [7:0]  p2_sync;

    // One write strobe per storage register
    logic        wr_p1_dir;
    logic        wr_p2_dir;
    logic        wr_p1_con;
    logic        wr_p2_con;
    logic        wr_p1_lth;
    logic        wr_p2_lth;

    // Raw and synced pad words
    pin_sync_if pins ();

    ////////////////////////////////////////////////////////////////////////////
    // Pad synchronisers
    ////////////////////////////////////////////////////////////////////////////

    // Pads change with no regard to the clock, so nothing reads them
    // before two flop stages have passed
    // pads through two flops
    assign pins.raw = {P2_PAD_IN, P1_PAD_IN};

    io_pin_sync u_sync (
        .CLK    (CLK),
        .RESETN (RESETN),
        .pins   (pins)
    );

    // Split the synced word back into its ports
    assign p1_sync = pins.synced[7:0];
    assign p2_sync = pins.synced[15:8];

    ////////////////////////////////////////////////////////////////////////////
    // Write decode
    ////////////////////////////////////////////////////////////////////////////

    // Pin state offsets get no strobe, so writes there are dropped
    // A write and a read in one cycle both act; the read sees the old value
    assign wr_p1_dir = WR && (ADDR == io_port_pkg::OFS_P1_DIRECTION);
    assign wr_p2_dir = WR && (ADDR == io_port_pkg::OFS_P2_DIRECTION);
    assign wr_p1_con = WR && (ADDR == io_port_pkg::OFS_P1_SOURCE);
    assign wr_p2_con = WR && (ADDR == io_port_pkg::OFS_P2_SOURCE);
    assign wr_p1_lth = WR && (ADDR == io_port_pkg::OFS_P1_LATCH);
    assign wr_p2_lth = WR && (ADDR == io_port_pkg::OFS_P2_LATCH);

    ////////////////////////////////////////////////////////////////////////////
    // Direction registers
    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            p1_dir_r <= io_port_pkg::RESET_BYTE;
            p2_dir_r <= io_port_pkg::RESET_BYTE;
        end else begin
            if (wr_p1_dir) begin
                p1_dir_r <= WDATA[7:0];
            end
            if (wr_p2_dir) begin
                p2_dir_r <= WDATA[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source select registers
    ////////////////////////////////////////////////////////////////////////////

    // port 1 resets to chip selects
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            p1_con_r <= io_port_pkg::RESET_BYTE;
            p2_con_r <= io_port_pkg::RESET_BYTE;
        end else begin
            if (wr_p1_con) begin
                p1_con_r <= WDATA[7:0];
            end
            if (wr_p2_con) begin
                p2_con_r <= WDATA[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output latch registers
    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            p1_lth_r <= io_port_pkg::RESET_BYTE;
            p2_lth_r <= io_port_pkg::RESET_BYTE;
        end else begin
            if (wr_p1_lth) begin
                p1_lth_r <= WDATA[7:0];
            end
            if (wr_p2_lth) begin
                p2_lth_r <= WDATA[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    ////////////////////////////////////////////////////////////////////////////

    // Upper byte reads zero; unmapped offsets read zero
    always_comb begin
        rdata_nxt = io_port_pkg::ZERO_WORD;
        if (RD) begin
            case (ADDR)
                io_port_pkg::OFS_P1_DIRECTION: rdata_nxt = {io_port_pkg::ZERO_BYTE, p1_dir_r};
                io_port_pkg::OFS_P2_DIRECTION: rdata_nxt = {io_port_pkg::ZERO_BYTE, p2_dir_r};
                io_port_pkg::OFS_P1_PIN_STATE: rdata_nxt = {io_port_pkg::ZERO_BYTE, p1_sync};
                io_port_pkg::OFS_P2_PIN_STATE: rdata_nxt = {io_port_pkg::ZERO_BYTE, p2_sync};
                io_port_pkg::OFS_P1_SOURCE:    rdata_nxt = {io_port_pkg::ZERO_BYTE, p1_con_r};
                io_port_pkg::OFS_P2_SOURCE:    rdata_nxt = {io_port_pkg::ZERO_BYTE, p2_con_r};
                io_port_pkg::OFS_P1_LATCH:     rdata_nxt = {io_port_pkg::ZERO_BYTE, p1_lth_r};
                io_port_pkg::OFS_P2_LATCH:     rdata_nxt = {io_port_pkg::ZERO_BYTE, p2_lth_r};
                default:                       rdata_nxt = io_port_pkg::ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rdata_r <= io_port_pkg::ZERO_WORD;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port 1 pin multiplexer
    ////////////////////////////////////////////////////////////////////////////

    // Port 1 has no input function, so its direction bits never reach here
    // chip select or latch
    always_comb begin
        p1_out_nxt = (p1_con_r & GENERAL_CHIP_SELECT) | (~p1_con_r & p1_lth_r);
    end

    // Port 1 drivers are always enabled, so only the level is registered
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            p1_out_r <= io_port_pkg::RESET_BYTE;
        end else begin
            p1_out_r <= p1_out_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port 2 pin multiplexer
    ////////////////////////////////////////////////////////////////////////////

    // Pure inputs keep drivers off whatever their control or latch hold
    always_comb begin
        p2_out_nxt = io_port_pkg::ZERO_BYTE;
        p2_oe_nxt  = io_port_pkg::ZERO_BYTE;

        p2_out_nxt[io_port_pkg::P2_TXD_BIT] = p2_con_r[io_port_pkg::P2_TXD_BIT] ?
            SERIAL1_TRANSMIT_DATA : p2_lth_r[io_port_pkg::P2_TXD_BIT];
        p2_oe_nxt[io_port_pkg::P2_TXD_BIT]  = 1'b1;

        p2_out_nxt[io_port_pkg::P2_SINT_BIT] = p2_con_r[io_port_pkg::P2_SINT_BIT] ?
            SERIAL1_INTERRUPT_OUT : p2_lth_r[io_port_pkg::P2_SINT_BIT];
        p2_oe_nxt[io_port_pkg::P2_SINT_BIT]  = 1'b1;

        p2_out_nxt[io_port_pkg::P2_RXD_BIT] = p2_con_r[io_port_pkg::P2_RXD_BIT] ?
            TRANSMIT_BUFFER_DATA : p2_lth_r[io_port_pkg::P2_RXD_BIT];
        p2_oe_nxt[io_port_pkg::P2_RXD_BIT] = SERIAL1_MODE0_TX;

        // Peripheral side is strapped to float and a latch one releases,
        // so only a latch zero with both selects clear pulls the pin low
        // direction one floats pin
        for (int i = io_port_pkg::P2_OD_LO; i <= io_port_pkg::P2_OD_HI; i++) begin
            p2_out_nxt[i] = 1'b0;
            p2_oe_nxt[i]  = ~p2_dir_r[i] & ~p2_con_r[i] & ~p2_lth_r[i];
        end
    end

    // Registered so pad drive cannot glitch on decode changes
    // Level and enable move together, so a pad never drives a stale bit
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            p2_out_r <= io_port_pkg::ZERO_BYTE;
            p2_oe_r  <= io_port_pkg::ZERO_BYTE;
        end else begin
            p2_out_r <= p2_out_nxt;
            p2_oe_r  <= p2_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////

    assign RDATA      = rdata_r;
    assign P1_PAD_OUT = p1_out_r;
    assign P2_PAD_OUT = p2_out_r;
    assign P2_PAD_OE  = p2_oe_r;

    // Also fed while the pad drives in mode 0, so the unit sees its own data
    // receive line always fed
    assign SERIAL1_RECEIVE_DATA = p2_sync[io_port_pkg::P2_RXD_BIT];
    // Synced port 2 levels for the serial unit's other inputs
    assign P2_PIN_LEVEL = p2_sync;

endmodule

//--- rtl/io_port_pkg.sv
// Purpose: Shared constants for the two-port general purpose I/O unit
// Assumes: 8-bit ports, 16-bit register data path, registers at even offsets
// Notes:   Only the low byte of each register is implemented

package io_port_pkg;

    // Data path widths
    localparam int PORT_W = 8;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int PIN_W  = 2 * PORT_W;

    // Register offsets within the peripheral block
    localparam logic [7:0] OFS_P1_DIRECTION = 8'h50;
    localparam logic [7:0] OFS_P1_PIN_STATE = 8'h52;
    localparam logic [7:0] OFS_P1_SOURCE    = 8'h54;
    localparam logic [7:0] OFS_P1_LATCH     = 8'h56;
    localparam logic [7:0] OFS_P2_DIRECTION = 8'h58;
    localparam logic [7:0] OFS_P2_PIN_STATE = 8'h5a;
    localparam logic [7:0] OFS_P2_SOURCE    = 8'h5c;
    localparam logic [7:0] OFS_P2_LATCH     = 8'h5e;

    // Reset value of the implemented low byte of direction, control, latch
    localparam logic [7:0] RESET_BYTE = 8'hff;
    // Upper register byte and idle values
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // Port 2 bit positions
    localparam int P2_RXD_BIT  = 0;
    localparam int P2_TXD_BIT  = 1;
    localparam int P2_SINT_BIT = 3;
    localparam int P2_OD_LO    = 6;
    localparam int P2_OD_HI    = 7;

    // Port 2 pins that are inputs; pin 0 also drives in mode 0
    localparam logic [7:0] P2_INPUT_MASK = 8'h35;

endpackage

//--- rtl/pin_sync_if.sv
// Purpose: Carries raw and synchronised pin levels between the top and its synchroniser
// Assumes: One clock domain
// Notes:   Port 1 pads in the low byte, port 2 pads in the high byte

`timescale 1ns/1ps

interface pin_sync_if;
    logic [15:0] raw;
    logic [15:0] synced;

    // Top drives raw levels and reads synced ones
    modport top  (output raw, input synced);
    // Synchroniser reads raw levels and returns synced ones
    modport sync (input raw, output synced);
endinterface

//--- rtl/io_pin_sync.sv
// Purpose: Two-stage synchroniser for every pad level of both ports
// Assumes: Single clock, synchronous active-low reset
// Notes:   First stage feeds only the second stage

`timescale 1ns/1ps

module io_pin_sync (
    input  wire logic   CLK,
    input  wire logic   RESETN,
    pin_sync_if.sync    pins
);

    ////////////////////////////////////////////////////////////////////////////
    // Per-bit synchroniser chain
    ////////////////////////////////////////////////////////////////////////////

    logic [io_port_pkg::PIN_W-1:0] stage1_r;
    logic [io_port_pkg::PIN_W-1:0] stage2_r;

    genvar gi;
    generate
        for (gi = 0; gi < io_port_pkg::PIN_W; gi++) begin : g_bit
            // Two flops so a metastable pad level never reaches the read path
            always_ff @(posedge CLK) begin
                if (!RESETN) begin
                    stage1_r[gi] <= 1'b0;
                    stage2_r[gi] <= 1'b0;
                end else begin
                    stage1_r[gi] <= pins.raw[gi];
                    stage2_r[gi] <= stage1_r[gi];
                end
            end
        end
    endgenerate

    // Synced levels back to the top
    assign pins.synced = stage2_r;

endmodule

//--- verification/io_port_mux_unit_asserts.sv
// Purpose: Port-level checks for the two-port I/O unit
// Assumes: Storage registers mirrored from bus writes
// Notes:   Pins and read data lag their causes by one clock
`timescale 1ns/1ps
module io_port_mux_unit_asserts (
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic [7:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic [7:0]  GENERAL_CHIP_SELECT,
    input wire logic        SERIAL1_TRANSMIT_DATA,
    input wire logic        SERIAL1_INTERRUPT_OUT,
    input wire logic        SERIAL1_MODE0_TX,
    input wire logic        TRANSMIT_BUFFER_DATA,
    input wire logic        SERIAL1_RECEIVE_DATA,
    input wire logic [7:0]  P2_PIN_LEVEL,
    input wire logic [7:0]  P2_PAD_IN,
    input wire logic [7:0]  P1_PAD_OUT,
    input wire logic [7:0]  P2_PAD_OUT,
    input wire logic [7:0]  P2_PAD_OE
);
    logic [7:0] sh_r [0:7];
    logic [7:0] p1_exp, rd_val;
    logic [1:0] od_exp;
    logic       tx_exp, si_exp, rx_exp, rd_st;
    ////////////////////////////////////////////////////////////
    // Mirror by offset slot; pin-state slots are never read back
    always_ff @(posedge CLK) begin
        for (int i = 0; i < 8; i++) begin
            if (!RESETN) begin
                sh_r[i] <= io_port_pkg::RESET_BYTE;
            end else if (WR && ADDR == io_port_pkg::OFS_P1_DIRECTION + 8'(2 * i)) begin
                sh_r[i] <= WDATA[7:0];
            end
        end
    end
    // Sources predicted from the mirror
    assign p1_exp = (sh_r[2] & GENERAL_CHIP_SELECT) | (~sh_r[2] & sh_r[3]);
    assign tx_exp = sh_r[6][1] ? SERIAL1_TRANSMIT_DATA : sh_r[7][1];
    assign si_exp = sh_r[6][3] ? SERIAL1_INTERRUPT_OUT : sh_r[7][3];
    assign rx_exp = sh_r[6][0] ? TRANSMIT_BUFFER_DATA : sh_r[7][0];
    assign od_exp = ~sh_r[4][7:6] & ~sh_r[6][7:6] & ~sh_r[7][7:6];
    assign rd_val = sh_r[ADDR[3:1]];
    assign rd_st  = RD && ADDR[7:4] == 4'h5 && !ADDR[0] && ADDR[2:0] != 3'h2;
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    property p_rd_idle; !RD |=> RDATA == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_fixed_oe; $past(RESETN) |-> P2_PAD_OE[1] && P2_PAD_OE[3] && P2_PAD_OE[5:4] == 2'h0 && !P2_PAD_OE[2];
    endproperty
    a_fixed_oe: assert property (p_fixed_oe) else $error("fixed enables wrong");
    property p_mode0; $past(RESETN) |-> P2_PAD_OE[0] == $past(SERIAL1_MODE0_TX); endproperty
    a_mode0: assert property (p_mode0) else $error("receive pin enable wrong");
    property p_sync;
        RESETN [*2] |=> P2_PIN_LEVEL == $past(P2_PAD_IN, 2) && SERIAL1_RECEIVE_DATA == $past(P2_PAD_IN[0], 2);
    endproperty
    a_sync: assert property (p_sync) else $error("pin sync wrong");
    property p_p1_mux; $past(RESETN) |-> P1_PAD_OUT == $past(p1_exp); endproperty
    a_p1_mux: assert property (p_p1_mux) else $error("port 1 mux wrong");
    property p_p2_mux;
        $past(RESETN) |-> P2_PAD_OUT[1] == $past(tx_exp) && P2_PAD_OUT[3] == $past(si_exp)
            && P2_PAD_OUT[0] == $past(rx_exp);
    endproperty
    a_p2_mux: assert property (p_p2_mux) else $error("port 2 mux wrong");
    property p_od; $past(RESETN) |-> P2_PAD_OE[7:6] == $past(od_exp) && P2_PAD_OUT[7:6] == 2'h0; endproperty
    a_od: assert property (p_od) else $error("open drain wrong");
    property p_reg_rd; rd_st |=> RDATA == {8'h00, $past(rd_val)}; endproperty
    a_reg_rd: assert property (p_reg_rd) else $error("register read wrong");
    property p_pin_rd; RD && ADDR == io_port_pkg::OFS_P2_PIN_STATE |=> RDATA == {8'h00, $past(P2_PIN_LEVEL)};
    endproperty
    a_pin_rd: assert property (p_pin_rd) else $error("pin read wrong");
    c_mode0: cover property (SERIAL1_MODE0_TX && sh_r[6][0]);
    c_od_drive: cover property (P2_PAD_OE[7:6] == 2'h3);
    c_pin_rd: cover property (RD && ADDR == io_port_pkg::OFS_P2_PIN_STATE);
endmodule
bind io_port_mux_unit io_port_mux_unit_asserts u_asserts (.CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .GENERAL_CHIP_SELECT, .SERIAL1_TRANSMIT_DATA, .SERIAL1_INTERRUPT_OUT, .SERIAL1_MODE0_TX,
    .TRANSMIT_BUFFER_DATA, .SERIAL1_RECEIVE_DATA, .P2_PIN_LEVEL, .P2_PAD_IN, .P1_PAD_OUT, .P2_PAD_OUT, .P2_PAD_OE);

//--- verification/io_board_model.sv
// Purpose: Board around the pads: readback and outside drivers
// Assumes: Pins 6 and 7 of port 2 carry no pull-ups on the board
// Notes:   Undriven pins take the level the bench asks for
`timescale 1ns/1ps
module io_board_model (
    input  wire logic [7:0] P1_PAD_OUT,
    input  wire logic [7:0] P2_PAD_OUT,
    input  wire logic [7:0] P2_PAD_OE,
    input  wire logic [7:0] EXT_LEVEL,
    output logic      [7:0] P1_PAD_IN,
    output logic      [7:0] P2_PAD_IN
);
    // Port 1 is always driven, so its pads read back the drive
    assign P1_PAD_IN = P1_PAD_OUT;
    // Released pins show the outside level, never the last drive
    assign P2_PAD_IN = (P2_PAD_OE & P2_PAD_OUT) | (~P2_PAD_OE & EXT_LEVEL);
endmodule

//--- verification/io_port_mux_unit_test.sv
// Purpose: Self-checking bench for the two-port I/O unit
// Assumes: Pins and read data one clock behind their causes
// Notes:   Reset values first, then register rows, mux, serial, sync, reset
`timescale 1ns/1ps
module io_port_mux_unit_test;
    typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} row_t;
    logic        CLK, RESETN, WR, RD, SERIAL1_TRANSMIT_DATA, SERIAL1_INTERRUPT_OUT;
    logic        SERIAL1_MODE0_TX, TRANSMIT_BUFFER_DATA, SERIAL1_RECEIVE_DATA;
    logic [7:0]  ADDR, GENERAL_CHIP_SELECT, EXT_LEVEL, P1_PAD_IN, P1_PAD_OUT;
    logic [7:0]  P2_PIN_LEVEL, P2_PAD_IN, P2_PAD_OUT, P2_PAD_OE;
    logic [15:0] WDATA, RDATA, got;
    logic [31:0] od_tab [4] = '{32'hff00000a, 32'h00c0000a, 32'h0000c00a, 32'h8000004a};
    int          err_total, n_compared;
    row_t        rows [7] = '{'{8'h50, 16'h005a, 16'h005a}, '{8'h58, 16'h003c, 16'h003c},
        '{8'h54, 16'h00a5, 16'h00a5}, '{8'h56, 16'h000f, 16'h000f}, '{8'h5c, 16'h0035, 16'h0035},
        '{8'h5e, 16'h00f4, 16'h00f4}, '{8'h60, 16'h0077, 16'h0000}};
    io_port_mux_unit dut (.CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA, .GENERAL_CHIP_SELECT,
        .SERIAL1_TRANSMIT_DATA, .SERIAL1_INTERRUPT_OUT, .SERIAL1_MODE0_TX, .TRANSMIT_BUFFER_DATA,
        .SERIAL1_RECEIVE_DATA, .P2_PIN_LEVEL, .P1_PAD_IN, .P1_PAD_OUT, .P2_PAD_IN, .P2_PAD_OUT, .P2_PAD_OE);
    io_board_model board (.P1_PAD_OUT, .P2_PAD_OUT, .P2_PAD_OE, .EXT_LEVEL, .P1_PAD_IN, .P2_PAD_IN);
    // 40 MHz clock
    always #12.5 CLK = ~CLK;
    ////////////////////////////////////////////////////////////
    // One-cycle strobes; a task never re-enters at the same edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD   <= 1'b0;
        #1;
        got = RDATA;
    endtask
    task automatic settle;
        repeat (2) @(posedge CLK);
        #1;
    endtask
    task automatic chk(input logic [15:0] exp, input logic [15:0] act);
        n_compared++;
        if (act !== exp) begin
            err_total++;
            $display("[ERR] %0t exp %h got %h", $time, exp, act);
        end
    endtask
    task automatic stop_test;
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (20000) @(posedge CLK);
        err_total++;
        stop_test;
    end
    initial begin
        {CLK, RESETN, WR, RD, ADDR, WDATA, SERIAL1_INTERRUPT_OUT, SERIAL1_MODE0_TX} = '0;
        {SERIAL1_TRANSMIT_DATA, TRANSMIT_BUFFER_DATA, GENERAL_CHIP_SELECT, EXT_LEVEL} = 18'h3_96ff;
        err_total = 0;
        n_compared = 0;
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        // Reset values of every storage register
        for (int i = 0; i < 8; i++) begin
            if (i != 1 && i != 5) begin
                rd(8'h50 + 8'(2 * i));
                chk(16'h00ff, got);
            end
        end
        chk(16'h0a96, {P2_PAD_OE, P1_PAD_OUT});
        chk(16'h0a03, {P2_PAD_OE, P2_PAD_OUT});
        // Upper bytes written as zero, unmapped offset last
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk(rows[i].e, got);
        end
        // Chip selects on high half, latch on low half
        wr(8'h54, 16'h00f0);
        wr(8'h56, 16'h0005);
        wr(8'h58, 16'h0000);
        wr(8'h5c, 16'h0000);
        wr(8'h5e, 16'h000a);
        settle;
        chk(16'h0095, {8'h00, P1_PAD_OUT});
        chk(16'hca0a, {P2_PAD_OE, P2_PAD_OUT});
        // Each way of floating the open drain pins
        foreach (od_tab[i]) begin
            wr(8'h58, {8'h00, od_tab[i][31:24]});
            wr(8'h5c, {8'h00, od_tab[i][23:16]});
            wr(8'h5e, {8'h00, od_tab[i][15:8]});
            settle;
            chk({8'h00, od_tab[i][7:0]}, {8'h00, P2_PAD_OE});
        end
        // Serial sources, then the receive pin in mode 0
        wr(8'h5c, 16'h000b);
        wr(8'h5e, 16'h0001);
        TRANSMIT_BUFFER_DATA  <= 1'b0;
        SERIAL1_INTERRUPT_OUT <= 1'b1;
        SERIAL1_TRANSMIT_DATA <= 1'b0;
        SERIAL1_MODE0_TX      <= 1'b1;
        settle;
        chk(16'h4b08, {P2_PAD_OE, P2_PAD_OUT});
        wr(8'h5c, 16'h000a);
        settle;
        chk(16'h4b09, {P2_PAD_OE, P2_PAD_OUT});
        @(posedge CLK);
        SERIAL1_MODE0_TX <= 1'b0;
        settle;
        chk(16'h4a09, {P2_PAD_OE, P2_PAD_OUT});
        // Pin state ignores writes and shows synced levels
        wr(8'h5a, 16'h0000);
        EXT_LEVEL           <= 8'ha5;
        GENERAL_CHIP_SELECT <= 8'h3c;
        settle;
        rd(8'h5a);
        chk(16'h00ad, got);
        chk(16'h01ad, {7'h00, SERIAL1_RECEIVE_DATA, P2_PIN_LEVEL});
        rd(8'h52);
        chk(16'h0035, got);
        // Second reset in mid-run
        @(posedge CLK);
        RESETN <= 1'b0;
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        settle;
        chk(16'h0a3c, {P2_PAD_OE, P1_PAD_OUT});
        rd(8'h5c);
        chk(16'h00ff, got);
        stop_test;
    end
endmodule
